// [igw_pkg.sv]
package igw_pkg;

	// ----------------------------------------
	// Record access messages
	// ----------------------------------------
	localparam logic [7:0] IGW_SVC_READ = 8'h32;
	localparam logic [7:0] IGW_SVC_WRITE = 8'h33;
	localparam logic [7:0] IGW_CLASS_PARAM = 8'h66;
	localparam int IGW_SLOT_POS = 8;
	localparam int IGW_FIELD_W = 8;
	localparam logic [7:0] IGW_IFACE_SLOT = 8'h00;
	localparam logic [7:0] IGW_REQ_SUB_1 = 8'h01;
	localparam logic [7:0] IGW_REQ_SUB_2 = 8'h02;
	localparam logic [7:0] IGW_REQ_SUB_3 = 8'h03;
	localparam logic [7:0] IGW_REQ_SUB_4 = 8'h04;
	localparam logic [15:0] IGW_IFACE_SUB_1 = 16'h0001;
	localparam logic [15:0] IGW_IFACE_SUB_2 = 16'h8000;
	localparam logic [15:0] IGW_IFACE_SUB_3 = 16'h8001;
	localparam logic [15:0] IGW_IFACE_SUB_4 = 16'h8002;

	// ----------------------------------------
	// Record index ranges
	// ----------------------------------------
	localparam logic [15:0] IGW_IDX_USER_MAX = 16'h7FFF;
	localparam logic [15:0] IGW_IDX_NORM_MAX = 16'hAFF0;
	localparam logic [15:0] IGW_IDX_IDENT_MAX = 16'hAFF3;

	// ----------------------------------------
	// Status bytes and fill
	// ----------------------------------------
	localparam int IGW_BIT_VALID = 7;
	localparam int IGW_BIT_FAULT = 6;
	localparam int IGW_BIT_DIAG = 0;
	localparam logic [7:0] IGW_STATUS_RESET = 8'h00;
	localparam logic [7:0] IGW_OUT_STATUS = 8'h80;
	localparam logic [7:0] IGW_FILL = 8'h00;

	// ----------------------------------------
	// Response framing and defaults
	// ----------------------------------------
	localparam logic [2:0] IGW_LEN_BYTES = 3'h4;
	localparam int IGW_NSUB = 8;
	localparam int IGW_MAXB = 16;
	localparam int IGW_FIFO_DEPTH = 16;

	typedef enum logic [10:0] {
		IGW_IDLE = 11'h001,
		IGW_IF_STAT = 11'h002,
		IGW_IF_PAD = 11'h004,
		IGW_IN_SEEK = 11'h008,
		IGW_IN_DATA = 11'h010,
		IGW_IN_FILL = 11'h020,
		IGW_IN_STAT = 11'h040,
		IGW_IN_PAD = 11'h080,
		IGW_OUT_SEEK = 11'h100,
		IGW_OUT_STAT = 11'h200,
		IGW_OUT_PAD = 11'h400
	} igw_walk_type;

endpackage

// [igw_gateway.sv]
// Functional notes
// (R1) Class 0x66, service 0x32 reads, 0x33 writes
// (R2) Instance is slot times 256 plus subslot
// (R3) Interface subslots 1..4 map to internal subslots
// (R4) Index ranges decide read/write or read-only
// (R5) Requester sends big-endian four-byte length
// (R6) Read answer: big-endian length, then data
// (R7) Byte mode: ascending order, no fill
// (R8) Word mode: fill after odd-length data
// (R9) Word mode: pad after each status byte
// (R10) Output image holds output data and padding
// (R11) Input status follows each input submodule's data
// (R12) Output status bytes grouped after input part
// (R13) Zero-length submodules count as input submodules
// (R14) Image starts with interface input status
// (R15) Status: valid bit7, fault bit6, diag bit0
// (R16) Fault on absent, wrong, bad parameters, startup
// (R17) Output status bytes always read 0x80
// (R18) Downstream failure zeroes inputs, status bad
// (R19) Shared submodules never report diagnostics
// (R20) Bad service or read-only write is refused

// ----------------------------------------
// Byte FIFO with registered head
// ----------------------------------------
module igw_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_reg;
	logic [AW-1:0] rptr_reg;
	logic [AW:0] cnt_reg;
	logic wr;
	logic rd;

	assign in_ready = cnt_reg < (AW+1)'(DEPTH);
	assign wr = in_valid & in_ready;
	assign rd = (cnt_reg != '0) & (~out_valid | out_ready);

	always_ff @(posedge mclk) begin
		if (ce && wr) begin
			mem[wptr_reg] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (ce) begin
			if (wr) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (rd) begin
				out_data <= mem[rptr_reg];
				rptr_reg <= rptr_reg + 1'b1;
				out_valid <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
			cnt_reg <= cnt_reg + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule

// ----------------------------------------
// Image builder and record gateway
// ----------------------------------------
module igw_gateway #(
	parameter int NSUB = igw_pkg::IGW_NSUB,
	parameter int MAXB = igw_pkg::IGW_MAXB,
	parameter int FIFO_DEPTH = igw_pkg::IGW_FIFO_DEPTH,
	parameter int LENW = $clog2(MAXB + 1)
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic word_mode,
	input wire logic link_ok,
	input wire logic startup_invalid,
	input wire logic iface_fault,
	input wire logic iface_diag,
	input wire logic [NSUB*LENW-1:0] sub_in_len,
	input wire logic [NSUB*LENW-1:0] sub_out_len,
	input wire logic [NSUB-1:0] sub_absent,
	input wire logic [NSUB-1:0] sub_wrong,
	input wire logic [NSUB-1:0] sub_param_bad,
	input wire logic [NSUB-1:0] sub_diag,
	input wire logic [NSUB-1:0] sub_shared,
	input wire logic [NSUB*MAXB*8-1:0] sub_in_data,
	input wire logic img_start,
	output logic [7:0] img_byte,
	output logic img_first,
	output logic img_valid,
	input wire logic img_ready,
	output logic img_busy,
	input wire logic [7:0] oimg_byte,
	input wire logic oimg_first,
	input wire logic oimg_valid,
	output logic [NSUB*MAXB*8-1:0] out_image_reg,
	input wire logic req_valid,
	input wire logic [7:0] req_service,
	input wire logic [7:0] req_class,
	input wire logic [15:0] req_instance,
	input wire logic [15:0] req_attribute,
	input wire logic [31:0] req_src,
	output logic rec_go_reg,
	output logic rec_err_reg,
	output logic rec_write_reg,
	output logic [7:0] rec_slot_reg,
	output logic [15:0] rec_subslot_reg,
	output logic [15:0] rec_index_reg,
	output logic [31:0] rec_len_reg,
	input wire logic rsp_start,
	input wire logic [31:0] rsp_count,
	input wire logic [7:0] rd_byte,
	input wire logic rd_valid,
	output logic rd_ready_reg,
	output logic [7:0] resp_byte_reg,
	output logic resp_valid_reg,
	input wire logic resp_ready,
	output logic resp_busy_reg
);
	import igw_pkg::*;

	localparam int EW = $clog2(NSUB) + 1;
	localparam int BW = $clog2(MAXB);

	// ----------------------------------------
	// Input image walker
	// ----------------------------------------
	igw_walk_type st_reg;
	logic [EW-1:0] ent_reg;
	logic [BW-1:0] byte_reg;
	logic first_reg;
	logic [EW-2:0] idx;
	logic [LENW-1:0] cur_in;
	logic [LENW-1:0] cur_out;
	logic cur_is_input;
	logic cur_fault;
	logic [7:0] in_status;
	logic [7:0] if_status;
	logic [7:0] emit_byte;
	logic emit;
	logic push_ready;
	logic step;

	assign idx = ent_reg[EW-2:0];
	assign cur_in = sub_in_len[idx*LENW +: LENW];
	assign cur_out = sub_out_len[idx*LENW +: LENW];
	assign cur_is_input = (cur_in != '0) | (cur_out == '0); // R13
	assign cur_fault = sub_absent[idx] | sub_wrong[idx] | sub_param_bad[idx] | startup_invalid; // R16

	always_comb begin
		in_status = IGW_STATUS_RESET; // R15
		in_status[IGW_BIT_VALID] = link_ok & ~cur_fault; // R18
		in_status[IGW_BIT_FAULT] = cur_fault; // R16
		in_status[IGW_BIT_DIAG] = sub_diag[idx] & ~sub_shared[idx]; // R19
		if_status = IGW_STATUS_RESET;
		if_status[IGW_BIT_VALID] = link_ok & ~iface_fault & ~startup_invalid; // R18
		if_status[IGW_BIT_FAULT] = iface_fault | startup_invalid;
		if_status[IGW_BIT_DIAG] = iface_diag;
	end

	always_comb begin
		emit = 1'b1;
		emit_byte = IGW_FILL;
		case (st_reg)
			IGW_IF_STAT: emit_byte = if_status; // R14
			IGW_IN_DATA: emit_byte = link_ok ? sub_in_data[(idx*MAXB + byte_reg)*8 +: 8] : IGW_FILL; // R18
			IGW_IN_STAT: emit_byte = in_status; // R11
			IGW_OUT_STAT: emit_byte = IGW_OUT_STATUS; // R17
			IGW_IF_PAD, IGW_IN_FILL, IGW_IN_PAD, IGW_OUT_PAD: emit_byte = IGW_FILL;
			default: emit = 1'b0;
		endcase
	end

	assign step = ~emit | push_ready;

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_reg <= IGW_IDLE;
			ent_reg <= '0;
			byte_reg <= '0;
			first_reg <= 1'b0;
		end else if (ce && step) begin
			case (st_reg)
				IGW_IDLE: begin
					if (img_start) begin
						st_reg <= IGW_IF_STAT; // R14
						first_reg <= 1'b1;
						ent_reg <= '0;
					end
				end
				IGW_IF_STAT: begin
					first_reg <= 1'b0;
					st_reg <= word_mode ? IGW_IF_PAD : IGW_IN_SEEK; // R9
				end
				IGW_IF_PAD: st_reg <= IGW_IN_SEEK;
				IGW_IN_SEEK: begin
					byte_reg <= '0;
					if (ent_reg == EW'(NSUB)) begin
						ent_reg <= '0;
						st_reg <= IGW_OUT_SEEK; // R12
					end else if (!cur_is_input) begin
						ent_reg <= ent_reg + 1'b1; // R7
					end else if (cur_in == '0) begin
						st_reg <= IGW_IN_STAT; // R13
					end else begin
						st_reg <= IGW_IN_DATA;
					end
				end
				IGW_IN_DATA: begin
					byte_reg <= byte_reg + 1'b1;
					if (LENW'(byte_reg) + 1'b1 == cur_in) begin
						st_reg <= (word_mode && cur_in[0]) ? IGW_IN_FILL : IGW_IN_STAT; // R8
					end
				end
				IGW_IN_FILL: st_reg <= IGW_IN_STAT; // R8
				IGW_IN_STAT: begin
					if (word_mode) begin
						st_reg <= IGW_IN_PAD; // R9
					end else begin
						ent_reg <= ent_reg + 1'b1;
						st_reg <= IGW_IN_SEEK; // R7
					end
				end
				IGW_IN_PAD: begin
					ent_reg <= ent_reg + 1'b1;
					st_reg <= IGW_IN_SEEK;
				end
				IGW_OUT_SEEK: begin
					if (ent_reg == EW'(NSUB)) begin
						st_reg <= IGW_IDLE;
					end else if (cur_out != '0) begin
						st_reg <= IGW_OUT_STAT; // R12
					end else begin
						ent_reg <= ent_reg + 1'b1;
					end
				end
				IGW_OUT_STAT: begin
					if (word_mode) begin
						st_reg <= IGW_OUT_PAD; // R9
					end else begin
						ent_reg <= ent_reg + 1'b1;
						st_reg <= IGW_OUT_SEEK;
					end
				end
				IGW_OUT_PAD: begin
					ent_reg <= ent_reg + 1'b1;
					st_reg <= IGW_OUT_SEEK;
				end
				default: st_reg <= IGW_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			img_busy <= 1'b0;
		end else if (ce) begin
			img_busy <= (st_reg != IGW_IDLE) | img_start;
		end
	end

	igw_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.in_data({first_reg, emit_byte}),
		.in_valid(emit & ce),
		.in_ready(push_ready),
		.out_data({img_first, img_byte}),
		.out_valid(img_valid),
		.out_ready(img_ready & ce)
	);

	// ----------------------------------------
	// Output image parser
	// ----------------------------------------
	logic [EW-1:0] oent_reg;
	logic [BW-1:0] obyte_reg;
	logic opad_reg;
	logic ofound;
	logic [EW-2:0] otgt;
	logic [LENW-1:0] olen;
	logic [BW-1:0] obyte;

	always_comb begin
		ofound = 1'b0;
		otgt = '0;
		for (int i = 0; i < NSUB; i++) begin
			if (!ofound && (oimg_first || EW'(i) >= oent_reg) && sub_out_len[i*LENW +: LENW] != '0) begin
				ofound = 1'b1;
				otgt = (EW-1)'(i);
			end
		end
		olen = sub_out_len[otgt*LENW +: LENW];
		obyte = oimg_first ? '0 : obyte_reg;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			oent_reg <= '0;
			obyte_reg <= '0;
			opad_reg <= 1'b0;
			out_image_reg <= '0;
		end else if (ce && oimg_valid) begin
			if (opad_reg && !oimg_first) begin
				opad_reg <= 1'b0; // R10
			end else if (ofound) begin
				out_image_reg[(otgt*MAXB + obyte)*8 +: 8] <= oimg_byte; // R10
				if (LENW'(obyte) + 1'b1 == olen) begin
					oent_reg <= EW'(otgt) + 1'b1;
					obyte_reg <= '0;
					opad_reg <= word_mode & olen[0]; // R8
				end else begin
					oent_reg <= EW'(otgt);
					obyte_reg <= obyte + 1'b1;
					opad_reg <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// Record request decode
	// ----------------------------------------
	logic svc_ok;
	logic is_write;
	logic ro_index;
	logic [7:0] req_slot;
	logic [7:0] req_sub;
	logic [15:0] map_sub;

	assign req_slot = req_instance[IGW_SLOT_POS +: IGW_FIELD_W]; // R2
	assign req_sub = req_instance[IGW_FIELD_W-1:0]; // R2
	assign is_write = req_service == IGW_SVC_WRITE; // R1
	assign svc_ok = (req_class == IGW_CLASS_PARAM) && (is_write || req_service == IGW_SVC_READ); // R1
	assign ro_index = (req_attribute > IGW_IDX_USER_MAX && req_attribute <= IGW_IDX_NORM_MAX)
		|| req_attribute > IGW_IDX_IDENT_MAX; // R4

	always_comb begin
		map_sub = {8'h00, req_sub};
		if (req_slot == IGW_IFACE_SLOT) begin
			case (req_sub)
				IGW_REQ_SUB_1: map_sub = IGW_IFACE_SUB_1; // R3
				IGW_REQ_SUB_2: map_sub = IGW_IFACE_SUB_2; // R3
				IGW_REQ_SUB_3: map_sub = IGW_IFACE_SUB_3; // R3
				IGW_REQ_SUB_4: map_sub = IGW_IFACE_SUB_4; // R3
				default: map_sub = {8'h00, req_sub};
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			rec_go_reg <= 1'b0;
			rec_err_reg <= 1'b0;
			rec_write_reg <= 1'b0;
			rec_slot_reg <= '0;
			rec_subslot_reg <= '0;
			rec_index_reg <= '0;
			rec_len_reg <= '0;
		end else if (ce) begin
			rec_go_reg <= 1'b0;
			rec_err_reg <= 1'b0;
			if (req_valid) begin
				if (!svc_ok || (is_write && ro_index)) begin
					rec_err_reg <= 1'b1; // R20
				end else begin
					rec_go_reg <= 1'b1;
					rec_write_reg <= is_write;
					rec_slot_reg <= req_slot;
					rec_subslot_reg <= map_sub;
					rec_index_reg <= req_attribute; // R4
					rec_len_reg <= req_src; // R5
				end
			end
		end
	end

	// ----------------------------------------
	// Read response serializer
	// ----------------------------------------
	logic [31:0] rsp_len_reg;
	logic [31:0] rsp_left_reg;
	logic [2:0] hdr_left_reg;
	logic slot_free;

	assign slot_free = ~resp_valid_reg | resp_ready;

	always_ff @(posedge mclk) begin
		if (reset) begin
			rsp_len_reg <= '0;
			rsp_left_reg <= '0;
			hdr_left_reg <= '0;
			rd_ready_reg <= 1'b0;
			resp_byte_reg <= '0;
			resp_valid_reg <= 1'b0;
			resp_busy_reg <= 1'b0;
		end else if (ce) begin
			if (resp_ready) begin
				resp_valid_reg <= 1'b0;
			end
			if (!resp_busy_reg) begin
				if (rsp_start) begin
					rsp_len_reg <= rsp_count;
					rsp_left_reg <= rsp_count;
					hdr_left_reg <= IGW_LEN_BYTES; // R6
					resp_busy_reg <= 1'b1;
				end
			end else if (hdr_left_reg != '0) begin
				if (slot_free) begin
					resp_byte_reg <= rsp_len_reg[(hdr_left_reg - 1'b1)*8 +: 8]; // R6
					resp_valid_reg <= 1'b1;
					hdr_left_reg <= hdr_left_reg - 1'b1;
				end
			end else if (rsp_left_reg == '0) begin
				resp_busy_reg <= 1'b0;
				rd_ready_reg <= 1'b0;
			end else if (rd_ready_reg) begin
				if (rd_valid) begin
					resp_byte_reg <= rd_byte; // R6
					resp_valid_reg <= 1'b1;
					rd_ready_reg <= 1'b0;
					rsp_left_reg <= rsp_left_reg - 1'b1;
				end
			end else if (slot_free) begin
				rd_ready_reg <= 1'b1;
			end
		end
	end
endmodule

// [igw_gateway_properties.sv]
module igw_gateway_properties (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic link_ok,
	input wire logic [7:0] img_byte,
	input wire logic img_first,
	input wire logic img_valid,
	input wire logic img_ready,
	input wire logic req_valid,
	input wire logic [7:0] req_service,
	input wire logic [7:0] req_class,
	input wire logic [15:0] req_instance,
	input wire logic [15:0] req_attribute,
	input wire logic rec_go_reg,
	input wire logic rec_err_reg,
	input wire logic [7:0] rec_slot_reg,
	input wire logic [15:0] rec_subslot_reg,
	input wire logic [15:0] rec_index_reg,
	input wire logic rsp_start,
	input wire logic [31:0] rsp_count,
	input wire logic [7:0] resp_byte_reg,
	input wire logic resp_valid_reg,
	input wire logic resp_busy_reg
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	// ----------------------------------------
	// Request decode, read answer and image stream
	// ----------------------------------------
	sequence s_req;
		ce && req_valid;
	endsequence
	sequence s_good_read;
		s_req ##0 (req_class == 8'h66 && req_service == 8'h32);
	endsequence
	sequence s_write;
		s_req ##0 (req_class == 8'h66 && req_service == 8'h33);
	endsequence
	sequence s_rsp_go;
		ce && rsp_start && !resp_busy_reg;
	endsequence

	AST_ONE_ANSWER: assert property (s_req |=> rec_go_reg != rec_err_reg)
		else $error("request not answered exactly once");
	AST_BAD_CLASS: assert property (s_req ##0 (req_class != 8'h66) |=> rec_err_reg)
		else $error("foreign class accepted");
	AST_BAD_SERVICE: assert property (s_req ##0 (req_service != 8'h32 && req_service != 8'h33) |=> rec_err_reg)
		else $error("unknown service accepted");
	AST_RO_WRITE: assert property (s_write ##0 (req_attribute >= 16'h8000 && req_attribute <= 16'hAFF0)
		|=> rec_err_reg && !rec_go_reg)
		else $error("write to read-only index accepted");
	AST_RW_WRITE: assert property (s_write ##0 (req_attribute <= 16'h7FFF
		|| (req_attribute >= 16'hAFF1 && req_attribute <= 16'hAFF3))
		|=> rec_go_reg && rec_index_reg == $past(req_attribute))
		else $error("writable index refused or not latched");
	AST_SLOT: assert property (s_good_read |=> rec_slot_reg == 8'($past(req_instance) >> 8))
		else $error("slot decode wrong");
	AST_IFACE_SUB: assert property (s_good_read ##0 (req_instance >= 16'h0002 && req_instance <= 16'h0004)
		|=> rec_subslot_reg == 16'h7FFE + $past(req_instance))
		else $error("interface subslot mapping wrong");
	AST_ERR_HOLD: assert property (rec_err_reg |-> $stable(rec_index_reg) && $stable(rec_slot_reg)
		&& $stable(rec_subslot_reg))
		else $error("refused request changed fields");
	AST_RSP_LEN: assert property (s_rsp_go |=> ##1 resp_valid_reg && resp_byte_reg == 8'($past(rsp_count, 2) >> 24))
		else $error("answer does not open with length MSB");
	AST_FIRST_STATUS: assert property (img_valid && img_first
		|-> img_byte[5:1] == 5'h00 && (link_ok || !img_byte[7]))
		else $error("leading status byte malformed");
	AST_IMG_HOLD: assert property (img_valid && !img_ready |=> img_valid && $stable(img_byte))
		else $error("image byte dropped while stalled");
endmodule

bind igw_gateway igw_gateway_properties u_props (.mclk, .reset, .ce, .link_ok, .img_byte, .img_first, .img_valid,
	.img_ready, .req_valid, .req_service, .req_class, .req_instance, .req_attribute, .rec_go_reg, .rec_err_reg,
	.rec_slot_reg, .rec_subslot_reg, .rec_index_reg, .rsp_start, .rsp_count, .resp_byte_reg, .resp_valid_reg,
	.resp_busy_reg);

// [igw_scanner.sv]
module igw_scanner (
	input wire logic mclk,
	input wire logic [7:0] img_byte,
	input wire logic img_first,
	input wire logic img_valid,
	output logic img_ready,
	input wire logic [7:0] resp_byte,
	input wire logic resp_valid,
	output logic resp_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] img_q[$];
	logic [7:0] rsp_q[$];
	int cyc = 0;

	// Stall both streams now and then
	assign img_ready = (cyc % 4) != 3;
	assign resp_ready = (cyc % 3) != 1;

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (img_valid && img_ready) begin
			if (img_first)
				img_q.delete();
			img_q.push_back(img_byte);
		end
		if (resp_valid && resp_ready)
			rsp_q.push_back(resp_byte);
	end
endmodule

// [igw_gateway_tb.sv]
module igw_gateway_tb;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
	$display("CHECK FAILED at %0t: got %h expected %h", $time, a, b); end end
	localparam int LW = 5;
	logic mclk = 0, reset = 1, ce = 1, word_mode = 0, link_ok = 1, startup_invalid = 0, iface_fault = 0;
	logic iface_diag = 1, img_start = 0, oimg_first = 0, oimg_valid = 0, req_valid = 0, rsp_start = 0, rd_valid = 1;
	logic [8*LW-1:0] sub_in_len, sub_out_len;
	logic [7:0] sub_absent, sub_wrong, sub_param_bad, sub_diag, sub_shared, img_byte, resp_byte_reg, rec_slot_reg;
	logic [1023:0] sub_in_data, out_image_reg;
	logic img_first, img_valid, img_ready, img_busy, rec_go_reg, rec_err_reg, rec_write_reg, rd_ready_reg;
	logic resp_valid_reg, resp_ready, resp_busy_reg;
	logic [7:0] oimg_byte = 0, req_service = 0, req_class = 0, rd_byte = 8'hA5;
	logic [15:0] req_instance = 0, req_attribute = 0, rec_subslot_reg, rec_index_reg;
	logic [31:0] req_src = 0, rsp_count = 0, rec_len_reg;
	int fail_count = 0, comparisons = 0, cycles = 0;
	int ilen[8] = '{0, 1, 0, 2, 0, 3, 0, 0};
	int olen[8] = '{2, 0, 1, 0, 0, 2, 0, 0};
	logic [7:0] exp_q[$];

	always #20 mclk = ~mclk;

	igw_gateway u_dut (.mclk, .reset, .ce, .word_mode, .link_ok, .startup_invalid, .iface_fault, .iface_diag,
		.sub_in_len, .sub_out_len, .sub_absent, .sub_wrong, .sub_param_bad, .sub_diag, .sub_shared, .sub_in_data,
		.img_start, .img_byte, .img_first, .img_valid, .img_ready, .img_busy, .oimg_byte, .oimg_first, .oimg_valid,
		.out_image_reg, .req_valid, .req_service, .req_class, .req_instance, .req_attribute, .req_src, .rec_go_reg,
		.rec_err_reg, .rec_write_reg, .rec_slot_reg, .rec_subslot_reg, .rec_index_reg, .rec_len_reg, .rsp_start,
		.rsp_count, .rd_byte, .rd_valid, .rd_ready_reg, .resp_byte_reg, .resp_valid_reg, .resp_ready, .resp_busy_reg);

	igw_scanner u_scan (.mclk, .img_byte, .img_first, .img_valid, .img_ready, .resp_byte(resp_byte_reg),
		.resp_valid(resp_valid_reg), .resp_ready);

	// Record data source advances on each accepted byte
	always @(posedge mclk)
		if (rd_ready_reg && rd_valid)
			rd_byte <= rd_byte + 8'h01;

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("Checks: %0d, failures: %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	function automatic logic [7:0] stat(int i, logic l, logic s);
		logic f;
		f = sub_absent[i] | sub_wrong[i] | sub_param_bad[i] | s;
		return {l & ~f, f, 5'h00, sub_diag[i] & ~sub_shared[i]};
	endfunction

	// ----------------------------------------
	// Input image build and compare
	// ----------------------------------------
	task automatic run_img(input logic w, input logic l, input logic s);
		int n;
		word_mode = w;
		link_ok = l;
		startup_invalid = s;
		exp_q = '{{l & ~iface_fault & ~s, iface_fault | s, 5'h00, iface_diag}};
		if (w) exp_q.push_back(8'h00);
		for (int i = 0; i < 8; i++)
			if (ilen[i] != 0 || olen[i] == 0) begin
				for (int b = 0; b < ilen[i]; b++)
					exp_q.push_back(l ? 8'(i * 16 + b) : 8'h00);
				if (w && ilen[i] % 2 == 1) exp_q.push_back(8'h00);
				exp_q.push_back(stat(i, l, s));
				if (w) exp_q.push_back(8'h00);
			end
		for (int i = 0; i < 8; i++)
			if (olen[i] != 0) begin
				exp_q.push_back(8'h80);
				if (w) exp_q.push_back(8'h00);
			end
		u_scan.img_q.delete();
		@(posedge mclk) #1 img_start = 1;
		@(posedge mclk) #1 img_start = 0;
		n = 0;
		while (u_scan.img_q.size() < exp_q.size() && n < 300) begin
			@(posedge mclk);
			n++;
		end
		repeat (4) @(posedge mclk);
		#1;
		`CHK(u_scan.img_q.size(), exp_q.size());
		`CHK(img_busy, 1'b0);
		foreach (exp_q[k]) `CHK(u_scan.img_q[k], exp_q[k]);
	endtask

	task automatic req(input logic [7:0] sv, input logic [7:0] cl, input logic [15:0] inst, input logic [15:0] idx,
		input logic err);
		@(posedge mclk) #1;
		req_valid = 1;
		req_service = sv;
		req_class = cl;
		req_instance = inst;
		req_attribute = idx;
		req_src = 32'h0000_0006;
		@(posedge mclk) #1;
		req_valid = 0;
		`CHK(rec_err_reg, err);
		`CHK(rec_go_reg, ~err);
	endtask

	logic [15:0] sub_map[4] = '{16'h0001, 16'h8000, 16'h8001, 16'h8002};
	logic [7:0] t_svc[8] = '{8'h33, 8'h33, 8'h33, 8'h33, 8'h33, 8'h32, 8'h34, 8'h32};
	logic [7:0] t_cls[8] = '{8'h66, 8'h66, 8'h66, 8'h66, 8'h66, 8'h66, 8'h66, 8'h67};
	logic [15:0] t_idx[8] = '{16'h8000, 16'hAFF0, 16'hAFF1, 16'hAFF3, 16'hAFF4, 16'hAFF4, 16'h0001, 16'h0001};
	logic t_err[8] = '{1, 1, 0, 0, 1, 0, 1, 1};

	initial begin
		for (int i = 0; i < 8; i++) begin
			sub_in_len[i*LW+:LW] = LW'(ilen[i]);
			sub_out_len[i*LW+:LW] = LW'(olen[i]);
			for (int b = 0; b < 16; b++)
				sub_in_data[(i*16+b)*8+:8] = 8'(i * 16 + b);
		end
		sub_absent = 8'h08;
		sub_wrong = 8'h40;
		sub_param_bad = 8'h80;
		sub_diag = 8'h22;
		sub_shared = 8'h20;
		repeat (10) @(posedge mclk);
		#1 reset = 0;
		run_img(0, 1, 0);
		run_img(1, 1, 0);
		run_img(1, 0, 1);
		// ----------------------------------------
		// Output image in word layout
		// ----------------------------------------
		for (int k = 0; k < 6; k++) begin
			@(posedge mclk) #1;
			oimg_valid = 1;
			oimg_first = (k == 0);
			oimg_byte = 8'hC0 + 8'(k);
		end
		@(posedge mclk) #1 oimg_valid = 0;
		@(posedge mclk) #1;
		`CHK(out_image_reg[15:0], 16'hC1C0);
		`CHK(out_image_reg[263:256], 8'hC2);
		`CHK(out_image_reg[655:640], 16'hC5C4);
		// ----------------------------------------
		// Record requests
		// ----------------------------------------
		for (int s = 1; s <= 4; s++) begin
			req(8'h32, 8'h66, 16'(s), 16'h0080, 0);
			`CHK(rec_subslot_reg, sub_map[s-1]);
		end
		req(8'h33, 8'h66, 16'h0301, 16'h7FFF, 0);
		`CHK({rec_slot_reg, rec_subslot_reg, rec_write_reg}, {8'h03, 16'h0001, 1'b1});
		`CHK({rec_index_reg, rec_len_reg}, {16'h7FFF, 32'h0000_0006});
		for (int t = 0; t < 8; t++)
			req(t_svc[t], t_cls[t], 16'h0502, t_idx[t], t_err[t]);
		`CHK({rec_index_reg, rec_write_reg, rec_slot_reg}, {16'hAFF4, 1'b0, 8'h05});
		@(posedge mclk) #1 {ce, req_valid, req_class} = {1'b0, 1'b1, 8'h66};
		@(posedge mclk) #1 {ce, req_valid} = 2'b10;
		`CHK({rec_go_reg, rec_err_reg}, 2'b00);
		// ----------------------------------------
		// Read answer
		// ----------------------------------------
		u_scan.rsp_q.delete();
		@(posedge mclk) #1;
		rsp_start = 1;
		rsp_count = 32'h0000_0002;
		@(posedge mclk) #1 rsp_start = 0;
		for (int n = 0; n < 100 && u_scan.rsp_q.size() < 6; n++)
			@(posedge mclk);
		#1;
		exp_q = '{8'h00, 8'h00, 8'h00, 8'h02, 8'hA5, 8'hA6};
		`CHK(u_scan.rsp_q.size(), 6);
		foreach (exp_q[k]) `CHK(u_scan.rsp_q[k], exp_q[k]);
		`CHK(resp_busy_reg, 1'b0);
		summarize();
	end
endmodule
